/* common/pstc_pkg.sv */
// Constants, codes and state type shared by the sector transfer sequencer
package pstc_pkg;
  localparam int BYTE_W      = 8;
  localparam int LBA_W       = 32;
  localparam int BLK_BYTES   = 64;  // Bytes per block
  localparam int BLKS_PER_SEC = 8;  // Blocks per sector
  localparam int PARAM_BYTES = 5;   // LBA bytes then count
  localparam int ADDR_W      = 6;   // Buffer address width
  localparam int PTR_W       = 7;   // Buffer pointer, reaches 64
  localparam int LEFT_W      = 11;  // Up to 255 * 8 blocks
  // Command codes on the host port (implementation constants)
  localparam logic [7:0] CMD_DISK_READ  = 8'h54;
  localparam logic [7:0] CMD_READ_GO    = 8'h55;
  localparam logic [7:0] CMD_DISK_WRITE = 8'h56;
  localparam logic [7:0] CMD_WRITE_GO   = 8'h57;
  localparam logic [7:0] CMD_FETCH_BLK  = 8'h27;
  localparam logic [7:0] CMD_PUSH_BLK   = 8'h2C;
  localparam logic [7:0] CMD_GET_STATUS = 8'h22;
  // Status codes (implementation constants)
  localparam logic [7:0] ST_DONE        = 8'h14;
  localparam logic [7:0] ST_BLK_READY   = 8'h1D;
  localparam logic [7:0] ST_BLK_WANTED  = 8'h1E;
  localparam logic [7:0] ST_MEDIA_FAULT = 8'h1F;
  localparam logic [7:0] ST_BAD_PARAM   = 8'h1A;
  // Reset values
  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] DOUT_RST       = 8'h00;
  typedef enum logic [2:0] {
    PSTC_IDLE, PSTC_PARAM, PSTC_EVAL, PSTC_FETCH,
    PSTC_WAIT_RGO, PSTC_WAIT_WGO, PSTC_STORE, PSTC_STORE_WAIT
  } pstc_state_t;
endpackage

/* common/pstc_buf_if.sv */
// Block buffer port bundle between sequencer and its buffer memory
`timescale 1ns/1ps
interface pstc_buf_if;
  import pstc_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [BYTE_W-1:0] wr_data;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [BYTE_W-1:0] rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

/* rtl/pstc_buf.sv */
// One 64-byte block buffer with registered read data
`timescale 1ns/1ps
module pstc_buf (
  input  wire logic CLK_I,   // System clock
  pstc_buf_if.mem   bus      // Buffer port
);
  import pstc_pkg::*;

  logic [BYTE_W-1:0] mem_r [BLK_BYTES];
  logic [BYTE_W-1:0] rd_data_r;

  // Storage array, no reset needed for data
  always_ff @(posedge CLK_I) begin
    if (bus.wr_en) begin
      mem_r[bus.wr_addr] <= bus.wr_data;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge CLK_I) begin
    if (bus.rd_en) begin
      rd_data_r <= mem_r[bus.rd_addr];
    end
  end

  assign bus.rd_data = rd_data_r;
endmodule

/* rtl/pstc_top.sv */
// Physical sector read/write command sequencer
`timescale 1ns/1ps
// Operation
// - Five parameter bytes: LBA LSB first, count
// - Sector counts 1 to 255 accepted
// - Eight 64-byte blocks per sector, then done
// - Read: fetch block, interrupt with block-ready
// - Read-continue resumes the ongoing read
// - Write: interrupt with block-wanted per block
// - Write-continue stores block, then re-evaluates
// - Storage fault ends transfer with fault status
// - N sectors give 8N+1 interrupts
// - Interrupt request output is active low
// - Only USB storage supported, not cards
module pstc_top (
  input  wire logic                         CLK_I,         // 200 MHz clock
  input  wire logic                         RST_B_I,       // Async reset, low
  input  wire logic                         CMD_WR_I,      // Command byte strobe
  input  wire logic                         DAT_WR_I,      // Data byte write strobe
  input  wire logic                         DAT_RD_I,      // Data byte read strobe
  input  wire logic [pstc_pkg::BYTE_W-1:0]  DIN_I,         // Host byte in
  output logic      [pstc_pkg::BYTE_W-1:0]  DOUT_O,        // Host byte out
  output logic                              INT_B_O,       // Interrupt, low
  input  wire logic                         MEDIA_USB_I,   // USB storage attached
  output logic                              STO_REQ_O,     // Block request pulse
  output logic                              STO_WRITE_O,   // Request is a write
  output logic      [pstc_pkg::LBA_W-1:0]   STO_LBA_O,     // Sector address
  output logic      [2:0]                   STO_BLK_O,     // Block in sector
  input  wire logic                         STO_RVALID_I,  // Read byte valid
  input  wire logic [pstc_pkg::BYTE_W-1:0]  STO_RDATA_I,   // Read byte
  output logic                              STO_WVALID_O,  // Write byte valid
  output logic      [pstc_pkg::BYTE_W-1:0]  STO_WDATA_O,   // Write byte
  input  wire logic                         STO_DONE_I,    // Block stored
  input  wire logic                         STO_ERR_I      // Storage fault
);
  import pstc_pkg::*;

  pstc_buf_if buf_bus ();
  pstc_buf i_pstc_buf (.CLK_I(CLK_I), .bus(buf_bus));

  pstc_state_t       state_r;
  logic [2:0]        pidx_r;
  logic [LBA_W-1:0]  lba_r;
  logic [7:0]        cnt_r;
  logic [LEFT_W-1:0] left_r;
  logic [2:0]        blk_r;
  logic              is_wr_r;
  logic [7:0]        status_r;
  logic              int_b_r;
  logic [PTR_W-1:0]  ptr_r;
  logic              fetch_act_r;
  logic              push_act_r;
  logic              host_pend_r;
  logic              sto_pend_r;
  logic [7:0]        dout_r;
  logic              sto_req_r;
  logic              sto_wvalid_r;
  logic [7:0]        sto_wdata_r;

  // Command decode
  logic cmd_read, cmd_write, cmd_rgo, cmd_wgo, cmd_fetch, cmd_push, cmd_stat;
  assign cmd_read  = CMD_WR_I && DIN_I == CMD_DISK_READ;
  assign cmd_write = CMD_WR_I && DIN_I == CMD_DISK_WRITE;
  assign cmd_rgo   = CMD_WR_I && DIN_I == CMD_READ_GO;
  assign cmd_wgo   = CMD_WR_I && DIN_I == CMD_WRITE_GO;
  assign cmd_fetch = CMD_WR_I && DIN_I == CMD_FETCH_BLK;
  assign cmd_push  = CMD_WR_I && DIN_I == CMD_PUSH_BLK;
  assign cmd_stat  = CMD_WR_I && DIN_I == CMD_GET_STATUS;

  // Transfer events
  logic last_param, params_ok, adv, fault, st_wr, host_rd, buf_wr;
  assign last_param = state_r == PSTC_PARAM && DAT_WR_I && pidx_r == 3'(PARAM_BYTES - 1);
  assign params_ok  = DIN_I != 8'h00 && MEDIA_USB_I;
  assign adv        = (state_r == PSTC_WAIT_RGO && cmd_rgo) ||
                      (state_r == PSTC_STORE_WAIT && STO_DONE_I && !STO_ERR_I);
  assign fault      = STO_ERR_I && (state_r == PSTC_FETCH || state_r == PSTC_STORE ||
                                    state_r == PSTC_STORE_WAIT);
  assign st_wr      = state_r == PSTC_STORE && !ptr_r[PTR_W-1];
  assign host_rd    = cmd_fetch || (fetch_act_r && DAT_RD_I && !ptr_r[PTR_W-1]);
  assign buf_wr     = (state_r == PSTC_FETCH && STO_RVALID_I) ||
                      (push_act_r && DAT_WR_I && !ptr_r[PTR_W-1]);

  // Interrupt source: one code per event
  logic       irq_set;
  logic [7:0] irq_code;
  always_comb begin
    irq_set  = 1'b0;
    irq_code = ST_DONE;
    if (fault) begin
      irq_set  = 1'b1;
      irq_code = ST_MEDIA_FAULT;
    end else if (last_param && !params_ok) begin
      irq_set  = 1'b1;
      irq_code = ST_BAD_PARAM;
    end else if (state_r == PSTC_EVAL) begin
      irq_set  = left_r == '0 || is_wr_r;
      irq_code = left_r == '0 ? ST_DONE : ST_BLK_WANTED;
    end else if (state_r == PSTC_FETCH && STO_RVALID_I && ptr_r == PTR_W'(BLK_BYTES - 1)) begin
      irq_set  = 1'b1;
      irq_code = ST_BLK_READY;
    end
  end

  // Sequencer; a new transfer command aborts any transfer in flight
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r <= PSTC_IDLE;
    end else if (cmd_read || cmd_write) begin
      state_r <= PSTC_PARAM;
    end else if (fault) begin
      state_r <= PSTC_IDLE;
    end else begin
      unique case (state_r)
        PSTC_IDLE:       state_r <= PSTC_IDLE;
        PSTC_PARAM:      if (last_param) state_r <= params_ok ? PSTC_EVAL : PSTC_IDLE;
        PSTC_EVAL: begin
          if (left_r == '0)  state_r <= PSTC_IDLE;
          else if (is_wr_r)  state_r <= PSTC_WAIT_WGO;
          else               state_r <= PSTC_FETCH;
        end
        PSTC_FETCH:      if (irq_set) state_r <= PSTC_WAIT_RGO;
        PSTC_WAIT_RGO:   if (cmd_rgo) state_r <= PSTC_EVAL;
        PSTC_WAIT_WGO:   if (cmd_wgo) state_r <= PSTC_STORE;
        PSTC_STORE:      if (ptr_r[PTR_W-1]) state_r <= PSTC_STORE_WAIT;
        PSTC_STORE_WAIT: if (STO_DONE_I) state_r <= PSTC_EVAL;
      endcase
    end
  end

  // Parameter capture, block position and remaining count
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pidx_r  <= 3'h0;
      lba_r   <= 32'h0000_0000;
      cnt_r   <= 8'h00;
      left_r  <= '0;
      blk_r   <= 3'h0;
      is_wr_r <= 1'b0;
    end else if (cmd_read || cmd_write) begin
      pidx_r  <= 3'h0;
      blk_r   <= 3'h0;
      is_wr_r <= cmd_write;
    end else if (state_r == PSTC_PARAM && DAT_WR_I) begin
      pidx_r <= pidx_r + 3'h1;
      if (last_param) begin
        cnt_r  <= DIN_I;
        left_r <= LEFT_W'({DIN_I, 3'h0});
      end else begin
        lba_r <= {DIN_I, lba_r[LBA_W-1:8]};
      end
    end else if (adv) begin
      left_r <= left_r - LEFT_W'(1);
      blk_r  <= blk_r + 3'h1;
      if (blk_r == 3'(BLKS_PER_SEC - 1)) lba_r <= lba_r + 32'h0000_0001;
    end
  end

  // Status code and active-low interrupt; a new event beats a status read
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      status_r <= STATUS_RST;
      int_b_r  <= 1'b1;
    end else if (irq_set) begin
      status_r <= irq_code;
      int_b_r  <= 1'b0;
    end else if (cmd_stat) begin
      int_b_r  <= 1'b1;
    end
  end

  // Buffer pointer and host block sessions
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ptr_r       <= '0;
      fetch_act_r <= 1'b0;
      push_act_r  <= 1'b0;
    end else begin
      if (cmd_fetch) begin
        ptr_r       <= PTR_W'(1);
        fetch_act_r <= 1'b1;
        push_act_r  <= 1'b0;
      end else if (cmd_push) begin
        ptr_r       <= '0;
        push_act_r  <= state_r == PSTC_WAIT_WGO;
        fetch_act_r <= 1'b0;
      end else if ((state_r == PSTC_EVAL) || (state_r == PSTC_WAIT_WGO && cmd_wgo)) begin
        ptr_r       <= '0;
        push_act_r  <= 1'b0;
        fetch_act_r <= 1'b0;
      end else if (host_rd || buf_wr || st_wr) begin
        ptr_r <= ptr_r + PTR_W'(1);
      end
    end
  end

  assign buf_bus.wr_en   = buf_wr;
  assign buf_bus.wr_addr = ptr_r[ADDR_W-1:0];
  assign buf_bus.wr_data = state_r == PSTC_FETCH ? STO_RDATA_I : DIN_I;
  assign buf_bus.rd_en   = host_rd || st_wr;
  assign buf_bus.rd_addr = cmd_fetch ? '0 : ptr_r[ADDR_W-1:0];

  // Host read data: status on request, block bytes two cycles after a read
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      host_pend_r <= 1'b0;
      dout_r      <= DOUT_RST;
    end else begin
      host_pend_r <= host_rd;
      if (cmd_stat) dout_r <= status_r;
      else if (host_pend_r) dout_r <= buf_bus.rd_data;
    end
  end

  // Storage side: request pulse and outgoing write stream
  // Write byte loads only with a valid read, so the unreset buffer never leaks unknowns
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sto_req_r    <= 1'b0;
      sto_pend_r   <= 1'b0;
      sto_wvalid_r <= 1'b0;
      sto_wdata_r  <= 8'h00;
    end else begin
      sto_req_r    <= (state_r == PSTC_EVAL && left_r != '0 && !is_wr_r) ||
                      (state_r == PSTC_WAIT_WGO && cmd_wgo);
      sto_pend_r   <= st_wr;
      sto_wvalid_r <= sto_pend_r;
      if (sto_pend_r) sto_wdata_r <= buf_bus.rd_data;
    end
  end

  assign DOUT_O       = dout_r;
  assign INT_B_O      = int_b_r;
  assign STO_REQ_O    = sto_req_r;
  assign STO_WRITE_O  = is_wr_r;
  assign STO_LBA_O    = lba_r;
  assign STO_BLK_O    = blk_r;
  assign STO_WVALID_O = sto_wvalid_r;
  assign STO_WDATA_O  = sto_wdata_r;

  // Checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  lba_order_a: assert property (last_param |-> ##1 lba_r[31:24] == $past(lba_r[31:24]))
    else $error("LBA changed on count byte");
  zero_refuse_a: assert property (last_param && DIN_I == 8'h00 |=>
    state_r == PSTC_IDLE && status_r == ST_BAD_PARAM) else $error("Zero count accepted");
  done_irq_a: assert property (state_r == PSTC_EVAL && left_r == '0 && !cmd_read &&
    !cmd_write |=> !INT_B_O && status_r == ST_DONE) else $error("Missing done status");
  fetch_req_a: assert property (state_r == PSTC_EVAL && left_r != '0 && !is_wr_r
    |=> STO_REQ_O && !STO_WRITE_O) else $error("Read block not requested");
  resume_read_a: assert property (state_r == PSTC_WAIT_RGO && cmd_rgo
    |=> state_r == PSTC_EVAL ##1 STO_REQ_O || left_r == '0) else $error("Read not resumed");
  want_irq_a: assert property (state_r == PSTC_EVAL && left_r != '0 && is_wr_r &&
    !cmd_read && !cmd_write |=> !INT_B_O && status_r == ST_BLK_WANTED)
    else $error("Block wanted not signalled");
  store_blk_a: assert property (state_r == PSTC_WAIT_WGO && cmd_wgo
    |=> STO_REQ_O && STO_WRITE_O ##3 STO_WVALID_O) else $error("Block not stored");
  fault_end_a: assert property (fault && !cmd_read && !cmd_write
    |=> state_r == PSTC_IDLE && status_r == ST_MEDIA_FAULT && !INT_B_O)
    else $error("Fault did not end transfer");
  blk_count_a: assert property (last_param && params_ok && !cmd_read && !cmd_write
    |=> left_r == LEFT_W'($past(DIN_I)) * LEFT_W'(BLKS_PER_SEC)) else $error("Block count wrong");
  stat_clear_a: assert property (cmd_stat && !irq_set |=> INT_B_O && DOUT_O == $past(status_r))
    else $error("Status read did not clear interrupt");
  card_refuse_a: assert property (last_param && !MEDIA_USB_I |=> status_r == ST_BAD_PARAM)
    else $error("Non-USB medium accepted");

  done_seen_c:  cover property (state_r == PSTC_EVAL && left_r == '0 && cnt_r != 8'h00);
  fault_seen_c: cover property (fault);
  read_loop_c:  cover property (state_r == PSTC_WAIT_RGO && cmd_rgo);
  write_loop_c: cover property (state_r == PSTC_STORE_WAIT && STO_DONE_I);
endmodule

/* testbench/pstc_storage_model.sv */
// Behavioural storage device answering the sequencer's block requests
`timescale 1ns/1ps
module pstc_storage_model (
  input  wire logic        clk_i,    // System clock
  input  wire logic        req_i,    // Block request
  input  wire logic        write_i,  // Request is a write
  input  wire logic [31:0] lba_i,    // Sector address
  input  wire logic [2:0]  blk_i,    // Block in sector
  input  wire logic        wvalid_i, // Write byte valid
  input  wire logic [7:0]  wdata_i,  // Write byte
  input  wire logic        slow_i,   // Stretch read bytes and write done, not faults
  input  wire logic        fail_i,   // Fault on next request
  output logic             rvalid_o, // Read byte valid
  output logic      [7:0]  rdata_o,  // Read byte
  output logic             done_o,   // Block stored
  output logic             err_o     // Storage fault
);
  logic [7:0]  wbuf [64];
  int          wcnt;
  logic [31:0] last_lba;
  // Sampled and driven on falling edges, clear of the design's updates
  initial begin
    rvalid_o = 1'b0;
    done_o = 1'b0;
    err_o = 1'b0;
    rdata_o = 8'h5A;
    wcnt = 0;
    forever begin
      @(negedge clk_i);
      if (req_i) begin
        last_lba = lba_i;
        if (fail_i) begin
          @(negedge clk_i);
          err_o = 1'b1;
          @(negedge clk_i);
          err_o = 1'b0;
        end else if (!write_i) begin
          for (int i = 0; i < 64; i++) begin
            repeat (slow_i ? 3 : 1) @(negedge clk_i);
            rvalid_o = 1'b1;
            rdata_o = (lba_i[7:0] ^ {blk_i, 5'h00}) + 8'(i);
            @(negedge clk_i);
            rvalid_o = 1'b0;
            rdata_o = ~rdata_o;  // Released bus must not look valid
          end
        end else begin
          wcnt = 0;
          for (int c = 0; c < 200 && wcnt < 64; c++) begin
            @(negedge clk_i);
            if (wvalid_i) begin
              wbuf[wcnt] = wdata_i;
              wcnt++;
            end
          end
          repeat (slow_i ? 20 : 1) @(negedge clk_i);
          done_o = 1'b1;
          @(negedge clk_i);
          done_o = 1'b0;
        end
      end
    end
  end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the sector transfer sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import pstc_pkg::*;
  logic        clk, rst_b, cmd_wr, dat_wr, dat_rd, media_usb, slow, fail;
  logic [7:0]  din, dout, rdata, wdata;
  logic        int_b, sto_req, sto_wr, rvalid, wvalid, sto_done, sto_err;
  logic [31:0] sto_lba;
  logic [2:0]  sto_blk;
  int          n_fail, comparisons, n_int;

  pstc_top i_pstc_top (.CLK_I(clk), .RST_B_I(rst_b), .CMD_WR_I(cmd_wr),
    .DAT_WR_I(dat_wr), .DAT_RD_I(dat_rd), .DIN_I(din), .DOUT_O(dout),
    .INT_B_O(int_b), .MEDIA_USB_I(media_usb), .STO_REQ_O(sto_req),
    .STO_WRITE_O(sto_wr), .STO_LBA_O(sto_lba), .STO_BLK_O(sto_blk),
    .STO_RVALID_I(rvalid), .STO_RDATA_I(rdata), .STO_WVALID_O(wvalid),
    .STO_WDATA_O(wdata), .STO_DONE_I(sto_done), .STO_ERR_I(sto_err));
  pstc_storage_model i_pstc_storage_model (.clk_i(clk), .req_i(sto_req),
    .write_i(sto_wr), .lba_i(sto_lba), .blk_i(sto_blk), .wvalid_i(wvalid),
    .wdata_i(wdata), .slow_i(slow), .fail_i(fail), .rvalid_o(rvalid),
    .rdata_o(rdata), .done_o(sto_done), .err_o(sto_err));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One-cycle strobe: 0 command, 1 data write, 2 data read
  // Starts on a fresh falling edge so back-to-back calls never collide
  task automatic strobe(input int s, input logic [7:0] d);
    @(negedge clk);
    din = d;
    {cmd_wr, dat_wr, dat_rd} = 3'(3'b100 >> s);
    @(negedge clk);
    {cmd_wr, dat_wr, dat_rd} = 3'b000;
  endtask

  task automatic start(input logic [7:0] c, input logic [31:0] lba,
                       input logic [7:0] cnt);
    strobe(0, c);
    for (int i = 0; i < 4; i++) strobe(1, lba[8*i +: 8]);
    strobe(1, cnt);
  endtask

  // Host waits for the request, then reads the status, which clears it
  task automatic status(input logic [7:0] exp);
    int k;
    k = 0;
    while (int_b !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k == 20000) begin
      n_fail++;
      end_of_test();
    end
    n_int++;
    strobe(0, CMD_GET_STATUS);
    @(negedge clk);
    `CHK(dout, exp)
    `CHK(int_b, 1'b1)
  endtask

  // Read data lags each strobe by two cycles, so reads stay spaced
  task automatic fetch(input logic [31:0] lba, input logic [2:0] b);
    strobe(0, CMD_FETCH_BLK);
    for (int i = 0; i < 64; i++) begin
      if (i > 0) strobe(2, 8'h00);
      repeat (2) @(negedge clk);
      `CHK(dout, (lba[7:0] ^ {b, 5'h00}) + 8'(i))
    end
  endtask

  task automatic read_xfer(input logic [31:0] lba, input logic [7:0] cnt,
                           input logic sl);
    slow = sl;
    n_int = 0;
    start(CMD_DISK_READ, lba, cnt);
    for (int s = 0; s < cnt; s++)
      for (int b = 0; b < 8; b++) begin
        status(ST_BLK_READY);
        fetch(lba + s, 3'(b));
        strobe(0, CMD_READ_GO);
      end
    status(ST_DONE);
    `CHK(n_int, 8 * cnt + 1)
    `CHK(i_pstc_storage_model.last_lba, lba + cnt - 1)
  endtask

  // Each stored block is judged after the next request proves it landed
  task automatic write_xfer(input logic [31:0] lba, input logic [7:0] cnt,
                            input logic sl);
    slow = sl;
    n_int = 0;
    start(CMD_DISK_WRITE, lba, cnt);
    for (int k = 0; k <= 8 * cnt; k++) begin
      status(k < 8 * cnt ? ST_BLK_WANTED : ST_DONE);
      if (k > 0) begin
        `CHK(i_pstc_storage_model.wcnt, 64)
        `CHK(i_pstc_storage_model.last_lba, lba + (k - 1) / 8)
        for (int i = 0; i < 64; i++)
          `CHK(i_pstc_storage_model.wbuf[i], 8'(i * 3 + k - 1))
      end
      if (k < 8 * cnt) begin
        strobe(0, CMD_PUSH_BLK);
        for (int i = 0; i < 64; i++) strobe(1, 8'(i * 3 + k));
        strobe(0, CMD_WRITE_GO);
      end
    end
    `CHK(n_int, 8 * cnt + 1)
  endtask

  // Count limits, missing medium and a storage fault
  task automatic refusals();
    n_int = 0;
    start(CMD_DISK_READ, 32'h0000_0010, 8'h00);
    status(ST_BAD_PARAM);
    start(CMD_DISK_READ, 32'h0000_0010, 8'hFF);
    status(ST_BLK_READY);
    media_usb = 1'b0;
    start(CMD_DISK_WRITE, 32'h0000_0010, 8'h01);
    status(ST_BAD_PARAM);
    media_usb = 1'b1;
    fail = 1'b1;
    start(CMD_DISK_READ, 32'h0000_0020, 8'h03);
    status(ST_MEDIA_FAULT);
    fail = 1'b0;
    `CHK(n_int, 4)
  endtask

  initial begin
    rst_b = 1'b0;
    cmd_wr = 1'b0;
    dat_wr = 1'b0;
    dat_rd = 1'b0;
    din = 8'h00;
    media_usb = 1'b1;
    slow = 1'b0;
    fail = 1'b0;
    n_fail = 0;
    comparisons = 0;
    n_int = 0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    `CHK(int_b, 1'b1)
    read_xfer(32'h00FF_FFFE, 8'h04, 1'b0);
    write_xfer(32'h1234_56FF, 8'h02, 1'b1);
    read_xfer(32'h0000_0100, 8'h01, 1'b1);
    refusals();
    end_of_test();
  end
endmodule
